// ---- core/sine_lookup.v ----
// Quarter-wave sine lookup with sign and quadrant folding.
`timescale 1ns/1ns
`include "wavegen_defines.vh"
module sine_lookup (
    // Phase in, full turn is 2^16
    input wire [15:0] phase_i,
    // Signed sine, full scale 0x7fff
    output reg signed [15:0] sine_o
);
    reg [3:0] idx;
    reg signed [15:0] mag;
    // ----------------------------------------
    // Table
    // ----------------------------------------
    // Sixteen-step quarter table trades resolution for area; linear interpolation is omitted.
    function [15:0] quarter;
        input [3:0] i;
        begin
            case (i)
                4'h0: quarter = 16'h0000;
                4'h1: quarter = 16'h0c8b;
                4'h2: quarter = 16'h18f8;
                4'h3: quarter = 16'h2527;
                4'h4: quarter = 16'h30fb;
                4'h5: quarter = 16'h3c56;
                4'h6: quarter = 16'h471c;
                4'h7: quarter = 16'h5133;
                4'h8: quarter = 16'h5a81;
                4'h9: quarter = 16'h62f1;
                4'ha: quarter = 16'h6a6c;
                4'hb: quarter = 16'h70e1;
                4'hc: quarter = 16'h7640;
                4'hd: quarter = 16'h7a7c;
                4'he: quarter = 16'h7d89;
                default: quarter = 16'h7f61;
            endcase
        end
    endfunction
    always @* begin
        idx = phase_i[14] ? ~phase_i[13:10] : phase_i[13:10];
        mag = quarter(idx);
        sine_o = phase_i[15] ? -mag : mag;
    end
endmodule // sine_lookup

// ---- core/waveform_generator.v ----
// Multi-mode angle-synchronous analog waveform generator core with Wishbone registers.
`timescale 1ns/1ns
`include "wavegen_defines.vh"
// Behaviour
// RL1: Five modes: direct, sine, encoder, resolver, arbitrary.
// RL2: Eight direct plus eight waveform channels held.
// RL3: Direct mode: one to eight active channels.
// RL4: Direct value signed 16-bit, minus one..one.
// RL5: Sine mode: independent amplitude and phase outputs.
// RL6: Up to eight generators; unused channels idle.
// RL7: Pole-pair setting limited to 64.
// RL8: Electrical frequency equals speed times pole pairs.
// RL9: Output follows mechanical angle, not timebase.
// RL10: Phase source local only, or plus global.
// RL11: Global phase moves all outputs together.
// RL12: Local shift applied to electrical angle.
// RL13: Sine amplitude unsigned 16-bit, zero..one.
// RL14: Local phase signed 16-bit, half turn span.
// RL15: Applied phase slews toward new setpoint.
// RL16: Slew rate 16-bit; zero means immediate.
// RL17: Software should program nonzero slew rate.
// RL18: Encoder: sine and cosine ninety degrees apart.
// RL19: Encoder adds bias, saturates to full scale.
// RL20: Resolver envelopes multiplied by external carrier.
// RL21: Per-channel registers; one sample per period.
// RL22: Reset clears amplitudes, offsets, phases.
module waveform_generator (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output wire ack_o,
    // Angle source and resolver carrier
    input wire [15:0] mechanical_angle_in_i,
    input wire signed [15:0] carrier_i,
    // Outputs to the output multiplexer
    output reg [127:0] direct_level_o,
    output reg [127:0] wave_o,
    output reg sample_strobe_o
);
    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg [31:0] ctrl_r;
    reg [6:0] pole_pairs_r;
    reg [15:0] global_phase_offset_r;
    reg [15:0] direct_level_r [0:7];
    reg [15:0] sine_gain_r [0:7];
    reg [15:0] bias_r [0:7];
    reg [15:0] local_phase_setpoint_r [0:7];
    reg [15:0] phase_slew_rate_r [0:7];
    reg [15:0] phase_now_r [0:7];
    reg [31:0] slew_acc_r [0:7];
    reg ack_r;
    reg [6:0] sample_cnt_r;
    reg [2:0] ch_r;
    reg sample_run_r;
    wire [2:0] mode = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire [3:0] ch_count = ctrl_r[`CTRL_CNT_MSB:`CTRL_CNT_LSB];
    wire use_global = ctrl_r[`CTRL_GLOBAL_BIT];
    wire bus_req = cyc_i & stb_i;
    wire wr_go = bus_req & we_i & ~ack_r;
    wire [2:0] adr_ch = adr_i[`REG_CH_MSB:`REG_CH_LSB];
    integer i;
    integer k;
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nv;
        input [3:0] sel;
        begin
            merge = {sel[3] ? nv[31:24] : old[31:24], sel[2] ? nv[23:16] : old[23:16],
                     sel[1] ? nv[15:8] : old[15:8], sel[0] ? nv[7:0] : old[7:0]};
        end
    endfunction
    // Clamp a 17-bit signed sum to the signed 16-bit range.
    function [15:0] sat16;
        input signed [16:0] v;
        begin
            if (v > `POS_FULL) begin
                sat16 = 16'h7fff;
            end else if (v < `NEG_FULL) begin
                sat16 = 16'h8000;
            end else begin
                sat16 = v[15:0];
            end
        end
    endfunction
    function active;
        input [2:0] ch;
        input [3:0] cnt;
        begin
            active = ({1'b0, ch} < cnt);
        end
    endfunction
    // Pole-pair scaling; the product wraps modulo one turn on purpose.
    function [15:0] times_pp;
        input [15:0] a;
        input [6:0] p;
        begin
            times_pp = a * {9'h000, p};
        end
    endfunction
    // ----------------------------------------
    // Wishbone slave: one registered ack per request, one clock after it, cleared the cycle after
    // ----------------------------------------
    assign ack_o = ack_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req & ~ack_r) begin
            case (adr_i & `REG_GROUP_MASK)
                `REG_DIRECT_BASE: dat_o <= {16'h0000, direct_level_r[adr_ch]};
                `REG_GAIN_BASE: dat_o <= {16'h0000, sine_gain_r[adr_ch]};
                `REG_BIAS_BASE: dat_o <= {16'h0000, bias_r[adr_ch]};
                `REG_PHSET_BASE: dat_o <= {16'h0000, local_phase_setpoint_r[adr_ch]};
                `REG_SLEW_BASE: dat_o <= {16'h0000, phase_slew_rate_r[adr_ch]};
                `REG_PHNOW_BASE: dat_o <= {16'h0000, phase_now_r[adr_ch]};
                default: begin
                    case (adr_i)
                        `REG_CTRL: dat_o <= ctrl_r;
                        `REG_POLE_PAIRS: dat_o <= {25'h0000000, pole_pairs_r};
                        `REG_GLOBAL_PH: dat_o <= {16'h0000, global_phase_offset_r};
                        `REG_STATUS: dat_o <= {29'h00000000, ch_r};
                        `REG_MECH_ANGLE: dat_o <= {16'h0000, mechanical_angle_in_i};
                        default: dat_o <= 32'h0000_0000;
                    endcase
                end
            endcase
        end
    end
    // ----------------------------------------
    // Global configuration registers
    // ----------------------------------------
    wire [31:0] ctrl_wr = merge(ctrl_r, dat_i, sel_i);
    wire [31:0] pp_wr = merge({25'h0000000, pole_pairs_r}, dat_i, sel_i);
    wire [31:0] gph_wr = merge({16'h0000, global_phase_offset_r}, dat_i, sel_i);
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `CTRL_RESET;
            pole_pairs_r <= 7'h01;
            global_phase_offset_r <= 16'h0000;
        end else if (wr_go) begin
            case (adr_i)
                `REG_CTRL: begin
                    // Unsupported mode codes and counts above eight are refused, keeping old value.
                    if (ctrl_wr[`CTRL_MODE_MSB:`CTRL_MODE_LSB] <= `MODE_ARBITRARY &&
                        ctrl_wr[`CTRL_CNT_MSB:`CTRL_CNT_LSB] <= `MAX_CH) begin // [RL1] [RL3] [RL6]
                        ctrl_r <= {24'h000000, ctrl_wr[7:0]};
                    end
                end
                `REG_POLE_PAIRS: begin
                    if (pp_wr <= {25'h0000000, `MAX_POLE_PAIRS}) begin // [RL7]
                        pole_pairs_r <= pp_wr[6:0];
                    end
                end
                `REG_GLOBAL_PH: global_phase_offset_r <= gph_wr[15:0]; // [RL11]
                default: ;
            endcase
        end
    end
    // ----------------------------------------
    // Per-channel registers and phase slewing
    // ----------------------------------------
    // Slew step per sample: rate in degrees/s times 65536/360 per degree / sample rate.
    // Accumulated in 16.16 fixed point so that slow rates still advance.
    wire [31:0] wr_word = merge(32'h0000_0000, dat_i, sel_i);
    wire [15:0] diff = local_phase_setpoint_r[ch_r] - phase_now_r[ch_r];
    wire [15:0] diff_mag = diff[15] ? -diff : diff;
    wire [31:0] step = ({16'h0000, phase_slew_rate_r[ch_r]} * `SLEW_MUL / `SLEW_DIV) << `SLEW_SHIFT;
    // Carried fraction plus this step; the upper half is the whole phase codes to move now.
    wire [31:0] slew_sum = {16'h0000, slew_acc_r[ch_r][15:0]} + step;
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < `NUM_CH; i = i + 1) begin
                direct_level_r[i] <= 16'h0000; // [RL22]
                sine_gain_r[i] <= 16'h0000; // [RL22]
                bias_r[i] <= 16'h0000; // [RL22]
                local_phase_setpoint_r[i] <= 16'h0000;
                phase_slew_rate_r[i] <= 16'h0000;
                phase_now_r[i] <= 16'h0000; // [RL22]
                slew_acc_r[i] <= 32'h0000_0000;
            end
        end else begin
            if (wr_go) begin
                case (adr_i & `REG_GROUP_MASK)
                    `REG_DIRECT_BASE: direct_level_r[adr_ch] <= wr_word[15:0]; // [RL4]
                    `REG_GAIN_BASE: sine_gain_r[adr_ch] <= wr_word[15:0]; // [RL13]
                    `REG_BIAS_BASE: bias_r[adr_ch] <= wr_word[15:0];
                    `REG_PHSET_BASE: local_phase_setpoint_r[adr_ch] <= wr_word[15:0]; // [RL14]
                    `REG_SLEW_BASE: phase_slew_rate_r[adr_ch] <= wr_word[15:0]; // [RL16]
                    default: ;
                endcase
            end
            if (sample_run_r) begin
                if (phase_slew_rate_r[ch_r] == 16'h0000) begin
                    phase_now_r[ch_r] <= local_phase_setpoint_r[ch_r]; // [RL16]
                    slew_acc_r[ch_r] <= 32'h0000_0000;
                end else if (diff != 16'h0000) begin
                    if (diff_mag <= slew_sum[31:16]) begin
                        phase_now_r[ch_r] <= local_phase_setpoint_r[ch_r];
                        slew_acc_r[ch_r] <= 32'h0000_0000;
                    end else begin
                        slew_acc_r[ch_r] <= {16'h0000, slew_sum[15:0]};
                        phase_now_r[ch_r] <= diff[15] ? // [RL15]
                            phase_now_r[ch_r] - slew_sum[31:16] :
                            phase_now_r[ch_r] + slew_sum[31:16];
                    end
                end
            end
        end
    end
    // ----------------------------------------
    // Sample sequencer: one channel per clock after each sample tick
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            sample_cnt_r <= 7'h00;
            ch_r <= 3'h0;
            sample_run_r <= 1'b0;
            sample_strobe_o <= 1'b0;
        end else begin
            sample_strobe_o <= 1'b0;
            if (sample_cnt_r == `SAMPLE_CNT_MAX) begin
                sample_cnt_r <= 7'h00;
                sample_run_r <= 1'b1; // [RL21]
                ch_r <= 3'h0;
            end else begin
                sample_cnt_r <= sample_cnt_r + 7'h01;
                if (sample_run_r) begin
                    ch_r <= ch_r + 3'h1;
                    if (ch_r == 3'h7) begin
                        sample_run_r <= 1'b0;
                        sample_strobe_o <= 1'b1;
                    end
                end
            end
        end
    end
    // ----------------------------------------
    // Angle path and output sample
    // ----------------------------------------
    // Electrical angle wraps modulo one turn, so only the low 16 bits of the product matter.
    wire [15:0] elec = times_pp(mechanical_angle_in_i, pole_pairs_r); // [RL8] [RL9]
    wire [15:0] glob = use_global ? times_pp(global_phase_offset_r, pole_pairs_r) : 16'h0000; // [RL10] [RL11]
    reg [15:0] cos_shift;
    always @* begin
        cos_shift = (mode == `MODE_ENCODER || mode == `MODE_RESOLVER) && ch_r[0] ? `QUARTER_TURN : 16'h0000;
    end
    wire [15:0] angle = elec + glob + phase_now_r[ch_r] + cos_shift; // [RL12] [RL18]
    wire signed [15:0] sine_val;
    sine_lookup u_lookup (
        .phase_i(angle),
        .sine_o(sine_val)
    );
    wire signed [31:0] scaled = $signed({{16{sine_val[15]}}, sine_val}) *
        $signed({17'h00000, sine_gain_r[ch_r][15:1]});
    wire signed [15:0] env = scaled[30:15];
    wire signed [31:0] modulated = $signed({{16{env[15]}}, env}) * $signed({{16{carrier_i[15]}}, carrier_i});
    reg [15:0] sample;
    always @* begin
        case (mode)
            `MODE_ENCODER: sample = sat16({env[15], env} + {bias_r[ch_r][15], bias_r[ch_r]}); // [RL19]
            `MODE_RESOLVER: sample = modulated[30:15]; // [RL20]
            `MODE_SINE, `MODE_ARBITRARY: sample = env; // [RL5]
            default: sample = 16'h0000;
        endcase
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            direct_level_o <= 128'h0;
            wave_o <= 128'h0;
        end else begin
            for (k = 0; k < `NUM_CH; k = k + 1) begin
                direct_level_o[k*16 +: 16] <= (mode == `MODE_DIRECT && active(k[2:0], ch_count)) ?
                    direct_level_r[k] : 16'h0000; // [RL2] [RL3]
            end
            if (sample_run_r) begin
                wave_o[ch_r*16 +: 16] <= (mode != `MODE_DIRECT && active(ch_r, ch_count)) ? sample : 16'h0000; // [RL6]
            end
        end
    end
endmodule // waveform_generator

// ---- inc/wavegen_defines.vh ----
// Constants shared by the analog waveform generator core and its sine lookup.
`ifndef WAVEGEN_DEFINES_VH
`define WAVEGEN_DEFINES_VH
// ----------------------------------------
// Register map (byte addresses, word aligned)
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_POLE_PAIRS  8'h04
`define REG_GLOBAL_PH   8'h08
`define REG_STATUS      8'h0c
`define REG_MECH_ANGLE  8'h10
`define REG_DIRECT_BASE 8'h40
`define REG_GAIN_BASE   8'h60
`define REG_BIAS_BASE   8'h80
`define REG_PHSET_BASE  8'ha0
`define REG_SLEW_BASE   8'hc0
`define REG_PHNOW_BASE  8'he0
`define REG_GROUP_MASK  8'he0
`define REG_CH_MSB      4
`define REG_CH_LSB      2
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_MODE_MSB   2
`define CTRL_MODE_LSB   0
`define CTRL_CNT_MSB    6
`define CTRL_CNT_LSB    3
`define CTRL_GLOBAL_BIT 7
`define CTRL_RESET      32'h0000_0000
// ----------------------------------------
// Operating modes
// ----------------------------------------
`define MODE_DIRECT     3'h0
`define MODE_SINE       3'h1
`define MODE_ENCODER    3'h2
`define MODE_RESOLVER   3'h3
`define MODE_ARBITRARY  3'h4
// ----------------------------------------
// Sizes and limits
// ----------------------------------------
`define NUM_CH          8
`define MAX_CH          4'h8
`define MAX_POLE_PAIRS  7'h40
`define POS_FULL        17'sh07fff
`define NEG_FULL        17'sh18000
`define QUARTER_TURN    16'h4000
// ----------------------------------------
// Timing: sample period and slew scaling
// ----------------------------------------
`define CLK_HZ          10000000
`define SAMPLE_HZ       100000
`define SAMPLE_CYCLES   (`CLK_HZ / `SAMPLE_HZ)
`define SAMPLE_CNT_MAX  7'h63
// Slew step in 16.16 phase codes per sample: rate times 65536/360/100000, times 65536.
// That is rate times 1.864 times 64; the division comes before the shift to stay within 32 bits.
`define SLEW_MUL        32'h0000_0748
`define SLEW_DIV        32'h0000_03e8
`define SLEW_SHIFT      6
`endif

// ---- test/mux_model.sv ----
// Behavioural output multiplexer: latches samples and supplies the resolver carrier.
`timescale 1ns/1ns
module mux_model (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // From the generator
    input wire [127:0] wave_i,
    input wire sample_strobe_i,
    // To the generator and the bench
    output reg signed [15:0] carrier_o,
    output reg [127:0] held_o
);
    // The carrier flips sign every clock, far above the envelope rate, so it is never a kind constant.
    always @(posedge clk_i) begin
        if (rst_i) begin
            carrier_o <= 16'sh7fff;
            held_o <= 128'h0;
        end else begin
            carrier_o <= -carrier_o;
            if (sample_strobe_i)
                held_o <= wave_i;
        end
    end
endmodule // mux_model

// ---- test/tb_top.sv ----
// Self-checking bench for the waveform generator.
`timescale 1ns/1ns
`include "wavegen_defines.vh"
module tb_top;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc_i = 1'b0;
    reg stb_i = 1'b0;
    reg we_i = 1'b0;
    reg [7:0] adr_i = 8'h00;
    reg [3:0] sel_i = 4'hf;
    reg [31:0] dat_i = 32'h0;
    reg [15:0] angle = 16'h0;
    wire [31:0] dat_o;
    wire ack_o;
    wire signed [15:0] carrier;
    wire [127:0] direct_level_o;
    wire [127:0] wave_o;
    wire sample_strobe_o;
    wire [127:0] held;
    integer errors = 0;
    integer checks = 0;
    integer m;
    reg [31:0] rd;
    always #50 clk_i = ~clk_i;
    waveform_generator waveform_generator_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .mechanical_angle_in_i(angle), .carrier_i(carrier), .direct_level_o(direct_level_o),
        .wave_o(wave_o), .sample_strobe_o(sample_strobe_o));
    mux_model mux_model_i (.clk_i(clk_i), .rst_i(rst_i), .wave_i(wave_o), .sample_strobe_i(sample_strobe_o),
        .carrier_o(carrier), .held_o(held));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task summarize;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= d;
            n = 0;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && n < 20) begin
                @(posedge clk_i);
                n = n + 1;
            end
            rd = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            if (n >= 20)
                chk("ack", 1, 0);
        end
    endtask
    task rdchk(input string what, input [7:0] a, input [31:0] exp);
        begin
            wb(1'b0, a, 32'h0);
            chk(what, exp, rd);
        end
    endtask
    // Waits for k sample strobes (the first period may be partial), then one edge so the model has latched.
    task samples(input integer k);
        integer n;
        begin
            repeat (k) begin
                n = 0;
                @(posedge clk_i);
                while (sample_strobe_o !== 1'b1 && n < 300) begin
                    @(posedge clk_i);
                    n = n + 1;
                end
                if (n >= 300)
                    chk("strobe", 1, 0);
            end
            @(posedge clk_i);
        end
    endtask
    function hi(input [15:0] v);
        hi = $signed(v) > 16'sh7000;
    endfunction
    function lo(input [15:0] v);
        lo = $signed(v) < -16'sh7000;
    endfunction
    function nz(input [15:0] v);
        nz = $signed(v) < 16'sh0010 && $signed(v) > -16'sh0010;
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        begin
            chk("wave", 0, wave_o[31:0] | wave_o[127:96]);
            rdchk("pole pairs", `REG_POLE_PAIRS, 32'h1);
        end
    endtask
    task t_modes;
        begin
            for (m = 0; m < 5; m = m + 1) begin
                wb(1'b1, `REG_CTRL, 32'h40 | m);
                rdchk("mode", `REG_CTRL, 32'h40 | m);
            end
            wb(1'b1, `REG_CTRL, 32'h45);
            rdchk("bad mode", `REG_CTRL, 32'h44);
            wb(1'b1, `REG_POLE_PAIRS, 32'h40);
            wb(1'b1, `REG_POLE_PAIRS, 32'h41);
            rdchk("pp limit", `REG_POLE_PAIRS, 32'h40);
            rdchk("unmapped", 8'h14, 32'h0);
        end
    endtask
    task t_direct;
        begin
            wb(1'b1, `REG_CTRL, 32'h10);
            wb(1'b1, `REG_DIRECT_BASE, 32'h8000);
            wb(1'b1, `REG_DIRECT_BASE + 8'h08, 32'h1234);
            repeat (3) @(posedge clk_i);
            chk("direct 0", 32'h8000, {16'h0, direct_level_o[15:0]});
            chk("direct 2 off", 0, {16'h0, direct_level_o[47:32]});
            wb(1'b1, `REG_CTRL, 32'h40);
            repeat (3) @(posedge clk_i);
            chk("direct 2 on", 32'h1234, {16'h0, direct_level_o[47:32]});
        end
    endtask
    task t_sine;
        begin
            wb(1'b1, `REG_CTRL, 32'h41);
            wb(1'b1, `REG_POLE_PAIRS, 32'h1);
            wb(1'b1, `REG_GAIN_BASE, 32'hffff);
            wb(1'b1, `REG_GAIN_BASE + 8'h04, 32'hffff);
            angle <= 16'h4000;
            samples(2);
            chk("pp1 crest", 1, hi(held[15:0]));
            wb(1'b1, `REG_POLE_PAIRS, 32'h2);
            samples(2);
            chk("pp2 zero", 1, nz(held[15:0]));
            wb(1'b1, `REG_PHSET_BASE, 32'h4000);
            samples(2);
            chk("local shift", 1, lo(held[15:0]));
            wb(1'b1, `REG_PHSET_BASE, 32'h0);
            wb(1'b1, `REG_POLE_PAIRS, 32'h1);
            wb(1'b1, `REG_GLOBAL_PH, 32'h4000);
            wb(1'b1, `REG_CTRL, 32'hc1);
            angle <= 16'h0;
            samples(2);
            chk("global 0", 1, hi(held[15:0]));
            chk("global 1", 1, hi(held[31:16]));
            wb(1'b1, `REG_CTRL, 32'h41);
            samples(2);
            chk("local only", 1, nz(held[15:0]));
            angle <= 16'h4000;
            wb(1'b1, `REG_CTRL, 32'h09);
            samples(2);
            chk("ch0 live", 1, hi(held[15:0]));
            chk("ch1 idle", 0, {16'h0, held[31:16]});
        end
    endtask
    task t_slew;
        begin
            wb(1'b1, `REG_SLEW_BASE, 32'h03e8);
            wb(1'b1, `REG_PHSET_BASE, 32'h4000);
            samples(2);
            wb(1'b0, `REG_PHNOW_BASE, 32'h0);
            chk("slewing", 1, rd[15:0] != 16'h0000 && rd[15:0] < 16'h0010);
            wb(1'b1, `REG_SLEW_BASE, 32'h0);
            samples(1);
            rdchk("abrupt", `REG_PHNOW_BASE, 32'h4000);
            wb(1'b1, `REG_PHSET_BASE, 32'h0);
        end
    endtask
    task t_encoder;
        begin
            wb(1'b1, `REG_CTRL, 32'h42);
            angle <= 16'h4000;
            samples(2);
            chk("enc sin", 1, hi(held[15:0]));
            chk("enc cos", 1, nz(held[31:16]));
            wb(1'b1, `REG_BIAS_BASE, 32'h7fff);
            samples(2);
            chk("sat high", 32'h7fff, {16'h0, held[15:0]});
            wb(1'b1, `REG_BIAS_BASE, 32'h8000);
            angle <= 16'hc000;
            samples(2);
            chk("sat low", 32'h8000, {16'h0, held[15:0]});
            wb(1'b1, `REG_BIAS_BASE, 32'h0);
            wb(1'b1, `REG_CTRL, 32'h43);
            samples(2);
            chk("resolver", 1, held[15:0] != 16'h0);
            wb(1'b1, `REG_CTRL, 32'h44);
            samples(2);
            chk("arbitrary", 1, lo(held[15:0]));
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_modes;
        t_direct;
        t_sine;
        t_slew;
        t_encoder;
        summarize;
    end
    initial begin
        #3000000;
        errors = errors + 1;
        summarize;
    end
endmodule // tb_top

// ---- test/wg_checker_properties.sv ----
// Port-level assertions for the waveform generator.
`timescale 1ns/1ns
module wg_checker (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Bus
    input wire cyc_i,
    input wire stb_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Outputs
    input wire [127:0] direct_level_o,
    input wire [127:0] wave_o,
    input wire sample_strobe_o
);
    reg [7:0] gap_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_answer;
        ack_o ##1 !ack_o;
    endsequence
    // Saturating, so a stuck strobe line cannot wrap the count back into range.
    always @(posedge clk_i) begin
        if (rst_i || sample_strobe_o)
            gap_r <= 8'h00;
        else if (gap_r != 8'hff)
            gap_r <= gap_r + 8'h01;
    end
    a_ack_answers_req: assert property (s_taken |=> s_answer)
        else $error("ack did not follow the request");
    a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    a_read_data_held: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
        else $error("read data moved while idle");
    a_reset_zeroes_outputs: assert property ($fell(rst_i) |-> direct_level_o == 128'h0 && wave_o == 128'h0)
        else $error("outputs not zero after reset");
    a_sample_period: assert property (gap_r < 8'd110)
        else $error("sample strobe missing");
    a_strobe_single: assert property (sample_strobe_o |=> !sample_strobe_o [*8])
        else $error("sample strobe too long");
    a_wave_on_sample: assert property ($changed(wave_o) |-> ##[0:9] sample_strobe_o)
        else $error("wave changed outside a sample");
    a_direct_on_write: assert property ($changed(direct_level_o) |-> ack_o || $past(ack_o) || $past(ack_o, 2))
        else $error("direct level changed without a write");
endmodule // wg_checker
bind waveform_generator wg_checker wg_checker_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .direct_level_o(direct_level_o),
    .wave_o(wave_o),
    .sample_strobe_o(sample_strobe_o)
);
